// ### rag_pkg.sv
package rag_pkg;
  localparam int PC_W        = 14;
  localparam int RAM_AW      = 10;
  localparam int WORD_W      = 10;
  localparam int PAGE_LSB    = 8;
  localparam int ZP_W        = 6;
  localparam int TBL_IMM_W   = 4;
  localparam int NIB_W       = 4;
  localparam int FLAG_AB_BIT = 8;
  localparam int FLAG_R_BIT  = 9;
  localparam int IDX_PAGE_W  = 2;
  localparam int IDX_ROW_W   = 4;
  localparam int IDX_COL_W   = 4;
  localparam logic [RAM_AW-1:0] MEMREG_BASE = 10'h040;
  localparam logic [3:0]        MEMREG_IDX_W = 4'h4;
  localparam logic [PC_W-1:0]   PC_RESET    = 14'h0000;
  localparam logic [7:0]        PAGE_LAST   = 8'hff;

  typedef enum logic [3:0] {
    RAG_OP_NONE,
    RAG_OP_IND,
    RAG_OP_DIRECT,
    RAG_OP_MEMREG,
    RAG_OP_LONG,
    RAG_OP_SHORT,
    RAG_OP_ZCALL,
    RAG_OP_TBRANCH,
    RAG_OP_TREAD
  } rag_op_t;

  typedef enum logic [1:0] {
    RAG_ST_IDLE,
    RAG_ST_DIRECT2,
    RAG_ST_TREAD
  } rag_state_t;
endpackage

// ### rag_tbl_route.sv
`timescale 1ns/1ps
module rag_tbl_route (
  input  wire logic [rag_pkg::WORD_W-1:0] rom_word,
  output logic                            wr_acc_b,
  output logic                            wr_port,
  output logic [7:0]                      data8
);
  always_comb begin
    wr_acc_b = rom_word[rag_pkg::FLAG_AB_BIT]; // RULE10
    wr_port  = rom_word[rag_pkg::FLAG_R_BIT];  // RULE11
    data8    = rom_word[7:0];
  end
endmodule // rag_tbl_route

// ### rag_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: indirect RAM address is page, row and column index registers joined into 10 bits.
// RULE2: direct RAM access is two words and the whole second word is the RAM address.
// RULE3: sixteen memory registers sit at 040 to 04f, reached only by their two instructions; here indirect and direct addresses can also reach them.
// RULE4: long jump, long branch and call load all 14 pc bits from the immediate.
// RULE5: short branch replaces pc bits 7..0 only, keeping the page bits of 64 pages of 256.
// RULE6: a short branch at the last word of a page lands in the following page.
// RULE7: zero-page call puts its 6-bit immediate in pc 5..0 and clears pc 13..6.
// RULE8: table branch target is built from a 4-bit immediate, accumulator and b register.
// RULE9: table target order is immediate, then b, then accumulator.
// RULE10: table read with word bit 8 set writes the low byte into accumulator and b.
// RULE11: table read with word bit 9 set writes the low byte into port one and two latches.
// RULE12: with both flag bits set, both destinations update in the same instruction.
// RULE13: table read leaves pc sequencing unchanged; the next instruction follows.
// RULE14: table read with neither flag bit set changes no register or latch.
module rag_top (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_b,
  input  wire logic                          op_valid,
  input  wire rag_pkg::rag_op_t              op_code,
  input  wire logic [rag_pkg::PC_W-1:0]      op_imm,
  input  wire logic [rag_pkg::IDX_PAGE_W-1:0] idx_page,
  input  wire logic [rag_pkg::IDX_ROW_W-1:0] idx_row,
  input  wire logic [rag_pkg::IDX_COL_W-1:0] idx_col,
  input  wire logic [rag_pkg::WORD_W-1:0]    second_word,
  input  wire logic                          second_valid,
  input  wire logic [rag_pkg::WORD_W-1:0]    rom_data,
  input  wire logic                          rom_valid,
  input  wire logic [rag_pkg::NIB_W-1:0]     acc_in,
  input  wire logic [rag_pkg::NIB_W-1:0]     b_in,
  output logic [rag_pkg::PC_W-1:0]           pc,
  output logic [rag_pkg::RAM_AW-1:0]         ram_addr,
  output logic                               ram_addr_valid,
  output logic                               memreg_sel,
  output logic [rag_pkg::PC_W-1:0]           rom_addr,
  output logic                               rom_rd,
  output logic [rag_pkg::NIB_W-1:0]          acc_out,
  output logic [rag_pkg::NIB_W-1:0]          b_out,
  output logic                               acc_b_we,
  output logic [rag_pkg::NIB_W-1:0]          port_one_out_latch,
  output logic [rag_pkg::NIB_W-1:0]          port_two_out_latch,
  output logic                               busy
);
  localparam int PW = rag_pkg::PC_W;
  localparam int AW = rag_pkg::RAM_AW;
  localparam int NW = rag_pkg::NIB_W;
  localparam int PL = rag_pkg::PAGE_LSB;
  localparam int ZW = rag_pkg::ZP_W;
  localparam int TW = rag_pkg::TBL_IMM_W;
  localparam int BW = 2 * rag_pkg::NIB_W;

  rag_pkg::rag_state_t state;
  logic [PW-1:0]       next_pc;
  logic [PW-1:0]       pc_inc;
  logic [PW-1:0]       pc_skip;
  logic [PW-1:0]       short_tgt;
  logic [PW-1:0]       zcall_tgt;
  logic [PW-1:0]       tbl_addr;
  logic [AW-1:0]       next_ram_addr;
  logic                next_ram_valid;
  logic [AW-1:0]       ind_addr;
  logic [AW-1:0]       memreg_addr;
  logic                page_last;
  logic                take;
  logic                take_ind;
  logic                take_direct;
  logic                take_memreg;
  logic                take_long;
  logic                take_short;
  logic                take_zcall;
  logic                take_tbranch;
  logic                take_tread;
  logic                second_done;
  logic                rom_done;
  logic                direct_wait;
  logic                tread_wait;
  logic                ab_write;
  logic                port_write;
  logic                wr_acc_b;
  logic                wr_port;
  logic [BW-1:0]       data8;

  // new instructions are only taken while idle
  assign take        = (state == rag_pkg::RAG_ST_IDLE) && op_valid;
  assign second_done = (state == rag_pkg::RAG_ST_DIRECT2) && second_valid;
  assign rom_done    = (state == rag_pkg::RAG_ST_TREAD) && rom_valid;
  assign direct_wait = (state == rag_pkg::RAG_ST_DIRECT2) && !second_valid;
  assign tread_wait  = (state == rag_pkg::RAG_ST_TREAD) && !rom_valid;

  // one strobe per accepted opcode
  always_comb begin
    take_ind     = 1'b0;
    take_direct  = 1'b0;
    take_memreg  = 1'b0;
    take_long    = 1'b0;
    take_short   = 1'b0;
    take_zcall   = 1'b0;
    take_tbranch = 1'b0;
    take_tread   = 1'b0;
    if (take) begin
      unique case (op_code)
        rag_pkg::RAG_OP_IND:     take_ind     = 1'b1;
        rag_pkg::RAG_OP_DIRECT:  take_direct  = 1'b1;
        rag_pkg::RAG_OP_MEMREG:  take_memreg  = 1'b1;
        rag_pkg::RAG_OP_LONG:    take_long    = 1'b1;
        rag_pkg::RAG_OP_SHORT:   take_short   = 1'b1;
        rag_pkg::RAG_OP_ZCALL:   take_zcall   = 1'b1;
        rag_pkg::RAG_OP_TBRANCH: take_tbranch = 1'b1;
        rag_pkg::RAG_OP_TREAD:   take_tread   = 1'b1;
        default: ;
      endcase
    end
  end

  // target and address forming
  assign pc_inc      = PW'(pc + PW'(1));
  assign pc_skip     = PW'(pc + PW'(2));
  assign page_last   = (pc[PL-1:0] == rag_pkg::PAGE_LAST);
  // the carry out of pc + 1 moves a page-end branch into the next page
  assign short_tgt   = page_last ? {pc_inc[PW-1:PL], op_imm[PL-1:0]}  // RULE6
                                 : {pc[PW-1:PL], op_imm[PL-1:0]};     // RULE5
  assign zcall_tgt   = PW'(op_imm[ZW-1:0]); // RULE7
  assign tbl_addr    = PW'({op_imm[TW-1:0], b_in, acc_in}); // RULE8 RULE9
  assign ind_addr    = {idx_page, idx_row, idx_col}; // RULE1
  assign memreg_addr = rag_pkg::MEMREG_BASE | AW'(op_imm[NW-1:0]); // RULE3

  rag_tbl_route u_route (
    .rom_word (rom_data),
    .wr_acc_b (wr_acc_b),
    .wr_port  (wr_port),
    .data8    (data8)
  );

  // table read destinations, each flag bit picks its own
  assign ab_write   = rom_done && wr_acc_b; // RULE10 RULE12 RULE14
  assign port_write = rom_done && wr_port; // RULE11 RULE12 RULE14

  // sequencer
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state <= rag_pkg::RAG_ST_IDLE;
    end else begin
      unique case (state)
        rag_pkg::RAG_ST_IDLE: begin
          if (take_direct) begin
            state <= rag_pkg::RAG_ST_DIRECT2; // RULE2
          end else if (take_tread) begin
            state <= rag_pkg::RAG_ST_TREAD;
          end
        end
        // wait for the second program word
        rag_pkg::RAG_ST_DIRECT2: begin
          if (second_valid) begin
            state <= rag_pkg::RAG_ST_IDLE;
          end
        end
        // wait for the referenced rom word
        rag_pkg::RAG_ST_TREAD: begin
          if (rom_valid) begin
            state <= rag_pkg::RAG_ST_IDLE;
          end
        end
        default: state <= rag_pkg::RAG_ST_IDLE;
      endcase
    end
  end

  // busy covers every state other than idle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      busy <= 1'b0;
    end else begin
      busy <= take_direct || take_tread || direct_wait || tread_wait;
    end
  end

  // next program counter
  always_comb begin
    next_pc = pc;
    if (take) begin
      unique case (op_code)
        rag_pkg::RAG_OP_LONG:    next_pc = op_imm; // RULE4
        rag_pkg::RAG_OP_SHORT:   next_pc = short_tgt; // RULE5 RULE6
        rag_pkg::RAG_OP_ZCALL:   next_pc = zcall_tgt; // RULE7
        rag_pkg::RAG_OP_TBRANCH: next_pc = tbl_addr; // RULE8
        rag_pkg::RAG_OP_DIRECT:  next_pc = pc_skip; // RULE2
        rag_pkg::RAG_OP_TREAD:   next_pc = pc_inc; // RULE13
        default:                 next_pc = pc_inc;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pc <= rag_pkg::PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  // RAM address source, one mode at a time
  always_comb begin
    next_ram_addr  = ram_addr;
    next_ram_valid = 1'b0;
    if (second_done) begin
      next_ram_addr  = second_word; // RULE2
      next_ram_valid = 1'b1;
    end else if (take_ind) begin
      next_ram_addr  = ind_addr; // RULE1
      next_ram_valid = 1'b1;
    end else if (take_memreg) begin
      next_ram_addr  = memreg_addr; // RULE3
      next_ram_valid = 1'b1;
    end
  end

  // address holds between accesses
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ram_addr <= '0;
    end else begin
      ram_addr <= next_ram_addr;
    end
  end

  // valid pulses for one cycle per access
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ram_addr_valid <= 1'b0;
    end else begin
      ram_addr_valid <= next_ram_valid;
    end
  end

  // marks an access made by the memory register instruction, not indirect or direct ones into 040 to 04f
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      memreg_sel <= 1'b0;
    end else begin
      memreg_sel <= take_memreg; // RULE3
    end
  end

  // table address of the word being fetched
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rom_addr <= '0;
    end else if (take_tread) begin
      rom_addr <= tbl_addr; // RULE10
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rom_rd <= 1'b0;
    end else begin
      rom_rd <= take_tread;
    end
  end

  // accumulator gets the low nibble, b the high one
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      acc_out <= '0;
    end else if (ab_write) begin
      acc_out <= data8[NW-1:0]; // RULE10
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      b_out <= '0;
    end else if (ab_write) begin
      b_out <= data8[BW-1:NW]; // RULE10
    end
  end

  // one-cycle write strobe for the accumulator pair
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      acc_b_we <= 1'b0;
    end else begin
      acc_b_we <= ab_write; // RULE12
    end
  end

  // port one gets the low nibble, port two the high one
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      port_one_out_latch <= '0;
    end else if (port_write) begin
      port_one_out_latch <= data8[NW-1:0]; // RULE11
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      port_two_out_latch <= '0;
    end else if (port_write) begin
      port_two_out_latch <= data8[BW-1:NW]; // RULE11
    end
  end
endmodule // rag_top

// ### rag_top_asserts.sv
`timescale 1ns/1ps
module rag_top_asserts (
  input wire logic             sys_clk, rst_b, op_valid, busy, rom_valid,
  input wire logic             rom_rd, acc_b_we, ram_addr_valid,
  input wire rag_pkg::rag_op_t op_code,
  input wire logic [13:0]      op_imm, pc,
  input wire logic [9:0]       rom_data, ram_addr,
  input wire logic [3:0]       idx_row, idx_col, acc_in, b_in, acc_out, b_out,
  input wire logic [3:0]       port_one_out_latch, port_two_out_latch,
  input wire logic [1:0]       idx_page
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [13:0] imm_q;
  logic [13:0] pc_q;
  logic [9:0]  rom_q;
  // one bit per accepted op code
  wire  [15:0] tk = (op_valid && !busy) ? 16'h0001 << op_code : 16'h0000;
  logic        in_tread;
  // rom words only count while a table read waits for one
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      in_tread <= 1'b0;
    end else if (tk[8]) begin
      in_tread <= 1'b1;
    end else if (rom_valid) begin
      in_tread <= 1'b0;
    end
  end
  wire         rv = in_tread && rom_valid;
  always_ff @(posedge sys_clk) begin
    imm_q <= op_imm;
    pc_q  <= pc;
    rom_q <= rom_data;
  end
  AST_IND: assert property (tk[1] |=> ram_addr_valid
    && ram_addr == {$past(idx_page), $past(idx_row), $past(idx_col)}) else $error("bad ind");
  AST_LONG: assert property (tk[4] |=> pc == $past(op_imm))
    else $error("bad long jump");
  AST_SHORT: assert property (tk[5] |=>
    pc == {pc_q[13:8] + {5'h00, &pc_q[7:0]}, imm_q[7:0]}) else $error("bad short branch");
  AST_ZCALL: assert property (tk[6] |=> pc == {8'h00, imm_q[5:0]})
    else $error("bad zero page call");
  AST_TBR: assert property (tk[7] |=>
    pc == {2'b00, imm_q[3:0], $past(b_in), $past(acc_in)}) else $error("bad table branch");
  AST_TREAD: assert property (tk[8] |=> rom_rd && pc == pc_q + 14'h0001)
    else $error("bad table read start");
  AST_AB: assert property (rv && rom_data[8] |=> acc_b_we && {b_out, acc_out} == rom_q[7:0])
    else $error("bad acc b write");
  AST_PORT: assert property (rv && rom_data[9] |=>
    {port_two_out_latch, port_one_out_latch} == rom_q[7:0]) else $error("bad port write");
  cover property (tk[5] && &pc[7:0]);
  cover property (rv && &rom_data[9:8]);
  cover property (rv && rom_data[9:8] == 2'b00);
endmodule // rag_top_asserts
bind rag_top rag_top_asserts u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .op_valid(op_valid),
  .busy(busy), .rom_valid(rom_valid), .rom_rd(rom_rd), .acc_b_we(acc_b_we),
  .ram_addr_valid(ram_addr_valid), .op_code(op_code), .op_imm(op_imm), .pc(pc),
  .rom_data(rom_data), .ram_addr(ram_addr), .idx_row(idx_row), .idx_col(idx_col),
  .acc_in(acc_in), .b_in(b_in), .acc_out(acc_out), .b_out(b_out), .idx_page(idx_page),
  .port_one_out_latch(port_one_out_latch), .port_two_out_latch(port_two_out_latch));

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic             sys_clk, rst_b, op_valid, second_valid, rom_valid;
  rag_pkg::rag_op_t op_code;
  logic [13:0]      op_imm, pc, rom_addr;
  logic [9:0]       second_word, rom_data, ram_addr;
  logic [3:0]       idx_row, idx_col, acc_in, b_in, acc_out, b_out, p1, p2, e1, e2;
  logic [1:0]       idx_page;
  logic             ram_addr_valid, memreg_sel, rom_rd, acc_b_we, busy;
  int               fails, check_count, cyc;
  rag_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
    .op_imm(op_imm), .idx_page(idx_page), .idx_row(idx_row), .idx_col(idx_col),
    .second_word(second_word), .second_valid(second_valid), .rom_data(rom_data),
    .rom_valid(rom_valid), .acc_in(acc_in), .b_in(b_in), .pc(pc), .ram_addr(ram_addr),
    .ram_addr_valid(ram_addr_valid), .memreg_sel(memreg_sel), .rom_addr(rom_addr),
    .rom_rd(rom_rd), .acc_out(acc_out), .b_out(b_out), .acc_b_we(acc_b_we),
    .port_one_out_latch(p1), .port_two_out_latch(p2), .busy(busy));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic op(input rag_pkg::rag_op_t c, input logic [13:0] i);
    @(negedge sys_clk);
    {op_valid, op_code, op_imm} = {1'b1, c, i};
    @(negedge sys_clk);
    op_valid = 1'b0;
  endtask
  task automatic t_ram;
    {idx_page, idx_row, idx_col} = 10'h3a5;
    op(rag_pkg::RAG_OP_IND, 14'h0000);
    chk({ram_addr_valid, ram_addr}, 14'h07a5);
    op(rag_pkg::RAG_OP_MEMREG, 14'h000f);
    chk({memreg_sel, ram_addr}, 14'h044f);
    op(rag_pkg::RAG_OP_DIRECT, 14'h0000);
    chk(busy, 14'h0001);
    {second_word, second_valid} = {10'h2c7, 1'b1};
    @(negedge sys_clk);
    second_valid = 1'b0;
    chk({ram_addr_valid, ram_addr}, 14'h06c7);
  endtask
  task automatic t_branch;
    op(rag_pkg::RAG_OP_LONG, 14'h2fff);
    chk(pc, 14'h2fff);
    op(rag_pkg::RAG_OP_SHORT, 14'h0012);
    chk(pc, 14'h3012);
    op(rag_pkg::RAG_OP_SHORT, 14'h00ee);
    chk(pc, 14'h30ee);
    op(rag_pkg::RAG_OP_ZCALL, 14'h3fff);
    chk(pc, 14'h003f);
    {b_in, acc_in} = 8'h5c;
    op(rag_pkg::RAG_OP_TBRANCH, 14'h000a);
    chk(pc, 14'h0a5c);
  endtask
  task automatic t_tread;
    for (int f = 0; f < 4; f++) begin
      {b_in, acc_in} = 8'h93;
      op(rag_pkg::RAG_OP_LONG, 14'h0100);
      op(rag_pkg::RAG_OP_TREAD, 14'h0006);
      chk({rom_rd, rom_addr[12:0]}, 14'h2693);
      chk(pc, 14'h0101);
      {rom_data, rom_valid} = {f[1:0], 8'ha0 | f[7:0], 1'b1};
      @(negedge sys_clk);
      rom_valid = 1'b0;
      if (f[1]) {e2, e1} = 8'ha0 | f[7:0];
      chk({busy, acc_b_we}, f[0]);
      if (f[0]) chk({b_out, acc_out}, 14'h00a0 | f[1:0]);
      chk({p2, p1}, {e2, e1});
    end
  endtask
  task final_report;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 400) begin
      fails++;
      final_report;
    end
  end
  initial begin
    {rst_b, op_valid, second_valid, rom_valid, op_imm, second_word, rom_data} = '0;
    {idx_page, idx_row, idx_col, acc_in, b_in, e1, e2} = '0;
    op_code = rag_pkg::RAG_OP_NONE;
    repeat (4) @(negedge sys_clk);
    rst_b = 1'b1;
    chk(pc, 14'h0000);
    t_ram;
    t_branch;
    t_tread;
    final_report;
  end
endmodule // tb_top
